// ### rtl/atic_pkg.sv
//----------------------------------------------------------------------
// atic_pkg: constants for the transmitter control slice
//----------------------------------------------------------------------
// Purpose: register map, field positions, reset values and block sizes.
// Assumes: byte-wide registers reached over the serial control port.
// Notes:   shared by atic_ctrl and atic_ram.
//
// How it works
// - delay bit 0 takes first bit right after frame sync edge; 1 adds one period.
// - edge select 0 samples audio data on rising bit clock, 1 on falling.
// - sync polarity 0 makes sync high the left phase; 1 makes low the left phase.
// - left word always precedes right word inside each frame.
// - enabled transfer-done event sets its flag after each copy and pulls interrupt low.
// - enabled slip event sets its flag on the chosen condition and pulls interrupt low.
// - an enable bit at 0 masks its event source; both reset to 0.
// - slip select 0 picks data slip, 1 picks block start.
// - trigger codes 00 rising, 01 falling, 10 level, 11 reserved.
// - transfer hold 0 allows buffer copies, 1 suppresses them.
// - two 48-byte status buffers, 24 bytes per channel, A and B interleaved.
// - encoder reads status bytes only from the encoder-side buffer.
// - host reaches only host-side buffer; device copies to encoder side itself.
// - power-down bit comes up set after reset until software clears it.
// - after re-enable, next copy happens during frames 184 to 191 of a block.
//----------------------------------------------------------------------

package atic_pkg;

  //--------------------------------------------------------------------
  // register offsets
  //--------------------------------------------------------------------
  localparam logic [5:0] REG_POWER   = 6'h02;
  localparam logic [5:0] REG_PORT    = 6'h03;
  localparam logic [5:0] REG_STATUS  = 6'h04;
  localparam logic [5:0] REG_ENABLE  = 6'h05;
  localparam logic [5:0] REG_TRIGGER = 6'h06;
  localparam logic [5:0] REG_BUFCTL  = 6'h07;
  localparam logic [5:0] BUF_BASE    = 6'h08;

  //--------------------------------------------------------------------
  // field positions
  //--------------------------------------------------------------------
  localparam int unsigned POWER_DOWN_BIT   = 0;
  localparam int unsigned DATA_DELAY_BIT   = 5;
  localparam int unsigned EDGE_SEL_BIT     = 6;
  localparam int unsigned SYNC_POL_BIT     = 7;
  localparam int unsigned XFER_DONE_BIT    = 0;
  localparam int unsigned SLIP_BIT         = 1;
  localparam int unsigned SLIP_SELECT_BIT  = 2;
  localparam int unsigned XFER_TRIG_LSB    = 0;
  localparam int unsigned SLIP_TRIG_LSB    = 2;
  localparam int unsigned TRANSFER_HOLD_BIT = 0;

  //--------------------------------------------------------------------
  // writable bits and reset values
  //--------------------------------------------------------------------
  localparam logic [7:0] POWER_MASK   = 8'h0F;
  localparam logic [7:0] ENABLE_MASK  = 8'h07;
  localparam logic [7:0] TRIGGER_MASK = 8'h0F;
  localparam logic [7:0] BUFCTL_MASK  = 8'h01;
  localparam logic [7:0] POWER_RST    = 8'h03;
  localparam logic [7:0] PORT_RST     = 8'h00;
  localparam logic [7:0] ENABLE_RST   = 8'h00;
  localparam logic [7:0] TRIGGER_RST  = 8'h00;
  localparam logic [7:0] BUFCTL_RST   = 8'h00;

  //--------------------------------------------------------------------
  // trigger mode codes
  //--------------------------------------------------------------------
  localparam logic [1:0] TRIG_RISE  = 2'h0;
  localparam logic [1:0] TRIG_FALL  = 2'h1;
  localparam logic [1:0] TRIG_LEVEL = 2'h2;

  //--------------------------------------------------------------------
  // sizes and frame positions
  //--------------------------------------------------------------------
  localparam int unsigned BUF_BYTES        = 48;
  localparam int unsigned BYTES_PER_CHAN   = 24;
  localparam int unsigned WORD_BITS        = 24;
  localparam int unsigned FRAMES_PER_BLOCK = 192;
  localparam int unsigned COPY_FIRST_FRAME = 184;
  localparam int unsigned COPY_LAST_FRAME  = 191;

endpackage : atic_pkg

// ### rtl/atic_ram.sv
//----------------------------------------------------------------------
// atic_ram: one channel status buffer
//----------------------------------------------------------------------
// Purpose: 48-byte buffer, one write port and one registered read port.
// Assumes: byte index runs 0..47, even index channel A, odd channel B.
// Notes:   reads beyond the buffer return zero.
//----------------------------------------------------------------------

module atic_ram (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // write port
  input  wire logic       wr_en,
  input  wire logic [5:0] wr_idx,
  input  wire logic [7:0] wr_data,
  // read port
  input  wire logic [5:0] rd_idx,
  output logic      [7:0] rd_data
);

  logic [7:0] mem [atic_pkg::BUF_BYTES];

  // byte store, interleaved A/B
  always_ff @(posedge ref_clk) begin
    if (wr_en && (32'(wr_idx) < atic_pkg::BUF_BYTES)) begin
      mem[wr_idx] <= wr_data;
    end
  end

  // registered read data
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else if (32'(rd_idx) < atic_pkg::BUF_BYTES) begin
      rd_data <= mem[rd_idx];
    end else begin
      rd_data <= 8'h00;
    end
  end

endmodule : atic_ram

// ### rtl/atic_ctrl.sv
//----------------------------------------------------------------------
// atic_ctrl: audio port framing, events and channel status buffers
//----------------------------------------------------------------------
// Purpose: control port slave, audio input framing, event flags and
//          the host-to-encoder channel status copy.
// Assumes: all pins are asynchronous to ref_clk and far slower.
// Notes:   control port is MSB first, sampled on cclk rise, driven on fall.
//----------------------------------------------------------------------

module atic_ctrl (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // serial control port
  input  wire logic        cp_cs_n,
  input  wire logic        cp_cclk,
  input  wire logic        cp_cdin,
  output logic             cp_cdout,
  output logic             cp_cdout_oe,
  output logic             int_n,
  // audio serial input
  input  wire logic        sclk,
  input  wire logic        frame_sync,
  input  wire logic        serial_audio_in,
  output logic [23:0]      left_word,
  output logic [23:0]      right_word,
  output logic             pair_valid,
  // encoder side
  input  wire logic        data_slip,
  input  wire logic [5:0]  enc_rd_idx,
  output logic [7:0]       enc_rd_data,
  output logic [7:0]       frame_index,
  output logic             block_start
);

  //--------------------------------------------------------------------
  // pin synchronisers
  //--------------------------------------------------------------------
  localparam int unsigned P_CS = 0;
  localparam int unsigned P_CK = 1;
  localparam int unsigned P_DI = 2;
  localparam int unsigned P_SC = 3;
  localparam int unsigned P_FS = 4;
  localparam int unsigned P_SD = 5;
  localparam logic [5:0]  PIN_RST = 6'h01;

  logic [5:0] pins;
  logic [5:0] sy0_reg;
  logic [5:0] sy1_reg;
  logic [5:0] sy2_reg;
  logic [5:0] filt_reg;
  logic [5:0] filt_next;
  logic [5:0] rise;
  logic [5:0] fall;

  assign pins = {serial_audio_in, frame_sync, sclk, cp_cdin, cp_cclk, cp_cs_n};

  // three-stage sync chain
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sy0_reg <= PIN_RST;
      sy1_reg <= PIN_RST;
      sy2_reg <= PIN_RST;
    end else begin
      sy0_reg <= pins;
      sy1_reg <= sy0_reg;
      sy2_reg <= sy1_reg;
    end
  end

  // a change counts once stages two and three agree
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      filt_next[i] = (sy1_reg[i] == sy2_reg[i]) ? sy2_reg[i] : filt_reg[i];
    end
    rise = filt_next & ~filt_reg;
    fall = ~filt_next & filt_reg;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      filt_reg <= PIN_RST;
    end else begin
      filt_reg <= filt_next;
    end
  end

  //--------------------------------------------------------------------
  // control registers
  //--------------------------------------------------------------------
  logic [7:0] power_reg;
  logic [7:0] port_reg;
  logic [7:0] enable_reg;
  logic [7:0] trigger_reg;
  logic [7:0] bufctl_reg;
  logic [1:0] status_reg;
  logic       wr_stb;
  logic [5:0] addr_reg;
  logic [7:0] new_byte;
  logic       power_down;
  logic       hold;

  assign power_down = power_reg[atic_pkg::POWER_DOWN_BIT];
  assign hold       = bufctl_reg[atic_pkg::TRANSFER_HOLD_BIT];

  // buffer window decode
  function automatic logic in_buffer(input logic [5:0] a);
    in_buffer = (a >= atic_pkg::BUF_BASE) &&
                (32'(a) < 32'(atic_pkg::BUF_BASE) + atic_pkg::BUF_BYTES);
  endfunction : in_buffer

  // register writes from the control port
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      power_reg   <= atic_pkg::POWER_RST;
      port_reg    <= atic_pkg::PORT_RST;
      enable_reg  <= atic_pkg::ENABLE_RST;
      trigger_reg <= atic_pkg::TRIGGER_RST;
      bufctl_reg  <= atic_pkg::BUFCTL_RST;
    end else if (wr_stb) begin
      unique case (addr_reg)
        atic_pkg::REG_POWER:   power_reg   <= new_byte & atic_pkg::POWER_MASK;
        atic_pkg::REG_PORT:    port_reg    <= new_byte;
        atic_pkg::REG_ENABLE:  enable_reg  <= new_byte & atic_pkg::ENABLE_MASK;
        atic_pkg::REG_TRIGGER: trigger_reg <= new_byte & atic_pkg::TRIGGER_MASK;
        atic_pkg::REG_BUFCTL:  bufctl_reg  <= new_byte & atic_pkg::BUFCTL_MASK;
        default: ;
      endcase
    end
  end

  //--------------------------------------------------------------------
  // serial control port
  //--------------------------------------------------------------------
  typedef enum logic [1:0] {CP_IDLE, CP_HEADER, CP_PAD, CP_DATA} atic_cp_state_type;

  atic_cp_state_type cp_state_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_in_reg;
  logic       read_mode_reg;
  logic       step_two_reg;
  logic       byte_done;
  logic       fetch_start;
  logic       cs_active;

  assign cs_active = ~filt_next[P_CS];
  assign new_byte  = {shift_in_reg[6:0], filt_next[P_DI]};
  assign byte_done = cs_active && rise[P_CK] && (bit_cnt_reg == 3'h7);
  assign wr_stb    = byte_done && (cp_state_reg == CP_DATA) && !read_mode_reg;
  assign fetch_start = byte_done && read_mode_reg &&
                       ((cp_state_reg == CP_PAD) || (cp_state_reg == CP_DATA));

  // header decode, bit count and address stepping
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !cs_active) begin
      cp_state_reg  <= CP_IDLE;
      bit_cnt_reg   <= 3'h0;
      shift_in_reg  <= 8'h00;
      read_mode_reg <= 1'b0;
      step_two_reg  <= 1'b0;
      addr_reg      <= 6'h00;
    end else begin
      if (cp_state_reg == CP_IDLE) begin
        cp_state_reg <= CP_HEADER;
      end
      if (rise[P_CK]) begin
        shift_in_reg <= new_byte;
        bit_cnt_reg  <= bit_cnt_reg + 3'h1;
      end
      if (byte_done) begin
        unique case (cp_state_reg)
          CP_IDLE, CP_HEADER: begin
            read_mode_reg <= new_byte[7];
            step_two_reg  <= new_byte[6];
            addr_reg      <= new_byte[5:0];
            cp_state_reg  <= CP_PAD;
          end
          CP_PAD: begin
            cp_state_reg <= CP_DATA;
          end
          CP_DATA: begin
            addr_reg <= addr_reg + (step_two_reg ? 6'h02 : 6'h01);
          end
        endcase
      end
    end
  end

  //--------------------------------------------------------------------
  // read fetch and data out
  //--------------------------------------------------------------------
  logic       fetch_pend_reg;
  logic       fetch_ram_reg;
  logic [5:0] fetch_addr_reg;
  logic [7:0] out_shift_reg;
  logic       oe_reg;
  logic       status_clr;
  logic       copy_busy_reg;
  logic [7:0] host_rd_data;
  logic [7:0] reg_rd_data;

  // register read mux, unmapped addresses and reserved bits read zero, except port register bits 4:0 and power register bits 3:1, which read back as written
  always_comb begin
    unique case (fetch_addr_reg)
      atic_pkg::REG_POWER:   reg_rd_data = power_reg;
      atic_pkg::REG_PORT:    reg_rd_data = port_reg;
      atic_pkg::REG_STATUS:  reg_rd_data = {6'h00, status_reg};
      atic_pkg::REG_ENABLE:  reg_rd_data = enable_reg;
      atic_pkg::REG_TRIGGER: reg_rd_data = trigger_reg;
      atic_pkg::REG_BUFCTL:  reg_rd_data = bufctl_reg;
      default:               reg_rd_data = 8'h00;
    endcase
  end

  assign status_clr = fetch_pend_reg && !in_buffer(fetch_addr_reg) &&
                      (fetch_addr_reg == atic_pkg::REG_STATUS);

  // fetch waits while a buffer copy owns the host-side read port
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fetch_pend_reg <= 1'b0;
      fetch_ram_reg  <= 1'b0;
      fetch_addr_reg <= 6'h00;
    end else begin
      fetch_ram_reg <= 1'b0;
      if (fetch_start) begin
        fetch_pend_reg <= 1'b1;
        fetch_addr_reg <= (cp_state_reg == CP_PAD) ? addr_reg
                          : addr_reg + (step_two_reg ? 6'h02 : 6'h01);
      end else if (fetch_pend_reg && (!in_buffer(fetch_addr_reg) || !copy_busy_reg)) begin
        fetch_pend_reg <= 1'b0;
        fetch_ram_reg  <= in_buffer(fetch_addr_reg);
      end
    end
  end

  // shift out on cclk fall, but never on the fall that opens a byte
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      out_shift_reg <= 8'h00;
    end else if (fetch_ram_reg) begin
      out_shift_reg <= host_rd_data;
    end else if (fetch_pend_reg && !in_buffer(fetch_addr_reg)) begin
      out_shift_reg <= reg_rd_data;
    end else if (fall[P_CK] && (bit_cnt_reg != 3'h0)) begin
      out_shift_reg <= {out_shift_reg[6:0], 1'b0};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= cs_active && read_mode_reg && (cp_state_reg == CP_DATA);
    end
  end

  assign cp_cdout    = out_shift_reg[7];
  assign cp_cdout_oe = oe_reg;

  //--------------------------------------------------------------------
  // audio serial input framing
  //--------------------------------------------------------------------
  logic        left_phase;
  logic        sync_edge;
  logic        frame_open;
  logic        sample_edge;
  logic        skip_reg;
  logic        was_left_reg;
  logic        have_left_reg;
  logic [4:0]  bit_pos_reg;
  logic [23:0] word_reg;

  assign left_phase  = filt_next[P_FS] ^ port_reg[atic_pkg::SYNC_POL_BIT];
  assign sync_edge   = (rise[P_FS] | fall[P_FS]) && !power_down;
  assign frame_open  = sync_edge && left_phase;
  assign sample_edge = port_reg[atic_pkg::EDGE_SEL_BIT] ? fall[P_SC] : rise[P_SC];

  // collect one word per phase, left-justified
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      skip_reg    <= 1'b0;
      bit_pos_reg <= 5'h00;
      word_reg    <= 24'h00_0000;
    end else if (sync_edge) begin
      skip_reg    <= port_reg[atic_pkg::DATA_DELAY_BIT];
      bit_pos_reg <= 5'h00;
      word_reg    <= 24'h00_0000;
    end else if (sample_edge && !power_down) begin
      if (skip_reg) begin
        skip_reg <= 1'b0;
      end else if (32'(bit_pos_reg) < atic_pkg::WORD_BITS) begin
        word_reg[5'(atic_pkg::WORD_BITS - 1) - bit_pos_reg] <= filt_next[P_SD];
        bit_pos_reg <= bit_pos_reg + 5'h01;
      end
    end
  end

  // hand out words, left always before right
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      left_word     <= 24'h00_0000;
      right_word    <= 24'h00_0000;
      pair_valid    <= 1'b0;
      was_left_reg  <= 1'b0;
      have_left_reg <= 1'b0;
    end else begin
      pair_valid <= 1'b0;
      if (sync_edge) begin
        was_left_reg <= left_phase;
        if (was_left_reg && !left_phase) begin
          left_word     <= word_reg;
          have_left_reg <= 1'b1;
        end else if (!was_left_reg && left_phase && have_left_reg) begin
          right_word    <= word_reg;
          pair_valid    <= 1'b1;
          have_left_reg <= 1'b0;
        end
      end
    end
  end

  //--------------------------------------------------------------------
  // frame position within the status block
  //--------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      frame_index <= 8'h00;
      block_start <= 1'b0;
    end else begin
      block_start <= 1'b0;
      if (frame_open) begin
        if (32'(frame_index) == atic_pkg::FRAMES_PER_BLOCK - 1) begin
          frame_index <= 8'h00;
          block_start <= 1'b1;
        end else begin
          frame_index <= frame_index + 8'h01;
        end
      end
    end
  end

  //--------------------------------------------------------------------
  // host-to-encoder buffer copy
  //--------------------------------------------------------------------
  logic       copied_reg;
  logic [5:0] copy_idx_reg;
  logic       copy_wr_reg;
  logic [5:0] copy_wr_idx_reg;
  logic       copy_end;
  logic       in_window;
  logic       done_cond_reg;
  logic       host_wr;
  logic [5:0] host_rd_idx;

  assign in_window = (32'(frame_index) >= atic_pkg::COPY_FIRST_FRAME) &&
                     (32'(frame_index) <= atic_pkg::COPY_LAST_FRAME);
  assign copy_end  = copy_wr_reg && (32'(copy_wr_idx_reg) == atic_pkg::BUF_BYTES - 1);

  // one copy per block, only inside the frame window and without hold
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      copy_busy_reg   <= 1'b0;
      copied_reg      <= 1'b0;
      copy_idx_reg    <= 6'h00;
      copy_wr_reg     <= 1'b0;
      copy_wr_idx_reg <= 6'h00;
    end else begin
      copy_wr_reg     <= copy_busy_reg;
      copy_wr_idx_reg <= copy_idx_reg;
      if (!in_window) begin
        copied_reg <= 1'b0;
      end
      if (!copy_busy_reg && !copied_reg && in_window && !hold && !power_down) begin
        copy_busy_reg <= 1'b1;
        copied_reg    <= 1'b1;
        copy_idx_reg  <= 6'h00;
      end else if (copy_busy_reg) begin
        if (32'(copy_idx_reg) == atic_pkg::BUF_BYTES - 1) begin
          copy_busy_reg <= 1'b0;
        end else begin
          copy_idx_reg <= copy_idx_reg + 6'h01;
        end
      end
    end
  end

  // host writes land only in the host-side buffer
  assign host_wr     = wr_stb && in_buffer(addr_reg);
  assign host_rd_idx = copy_busy_reg ? copy_idx_reg : fetch_addr_reg - atic_pkg::BUF_BASE;

  atic_ram u_host_buf (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .wr_en   (host_wr),
    .wr_idx  (addr_reg - atic_pkg::BUF_BASE),
    .wr_data (new_byte),
    .rd_idx  (host_rd_idx),
    .rd_data (host_rd_data)
  );

  // encoder reads only its own buffer, filled only by the copy
  atic_ram u_enc_buf (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .wr_en   (copy_wr_reg),
    .wr_idx  (copy_wr_idx_reg),
    .wr_data (host_rd_data),
    .rd_idx  (enc_rd_idx),
    .rd_data (enc_rd_data)
  );

  //--------------------------------------------------------------------
  // event flags and interrupt pin
  //--------------------------------------------------------------------
  logic [1:0] cond;
  logic [1:0] cond_prev_reg;
  logic [1:0] hit;

  // chosen edge or level of the event condition
  function automatic logic trig_hit(input logic [1:0] mode, input logic cur, input logic prev);
    unique case (mode)
      atic_pkg::TRIG_RISE:  trig_hit = cur & ~prev;
      atic_pkg::TRIG_FALL:  trig_hit = ~cur & prev;
      atic_pkg::TRIG_LEVEL: trig_hit = cur;
      default:              trig_hit = 1'b0;              // reserved code
    endcase
  endfunction : trig_hit

  // transfer-done stays up from copy end until the next frame opens
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      done_cond_reg <= 1'b0;
    end else if (copy_end) begin
      done_cond_reg <= 1'b1;
    end else if (frame_open) begin
      done_cond_reg <= 1'b0;
    end
  end

  assign cond[atic_pkg::XFER_DONE_BIT] = done_cond_reg;
  assign cond[atic_pkg::SLIP_BIT] = enable_reg[atic_pkg::SLIP_SELECT_BIT]
                                    ? (frame_index == 8'h00) : data_slip;

  always_comb begin
    hit[atic_pkg::XFER_DONE_BIT] = !hold && enable_reg[atic_pkg::XFER_DONE_BIT] &&
        trig_hit(trigger_reg[atic_pkg::XFER_TRIG_LSB +: 2], cond[0], cond_prev_reg[0]);
    hit[atic_pkg::SLIP_BIT] = enable_reg[atic_pkg::SLIP_BIT] &&
        trig_hit(trigger_reg[atic_pkg::SLIP_TRIG_LSB +: 2], cond[1], cond_prev_reg[1]);
  end

  // sticky flags, cleared by reading the status register; a set wins
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cond_prev_reg <= 2'h0;
      status_reg    <= 2'h0;
    end else begin
      cond_prev_reg <= cond;
      status_reg    <= hit | (status_clr ? 2'h0 : status_reg);
    end
  end

  // pin low while any enabled flag stands
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      int_n <= 1'b1;
    end else begin
      int_n <= ~|(status_reg & enable_reg[1:0]);
    end
  end

endmodule : atic_ctrl

// ### dv/atic_ctrl_sva.sv
// Purpose: port checks for atic_ctrl
// Assumes: synchronous active-low reset
// Notes:   bound to every atic_ctrl instance
module atic_ctrl_sva (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // control port and interrupt
  input wire logic        cp_cs_n,
  input wire logic        cp_cdout_oe,
  input wire logic        int_n,
  // audio words
  input wire logic        pair_valid,
  input wire logic [23:0] left_word,
  // encoder side
  input wire logic        block_start,
  input wire logic [5:0]  enc_rd_idx,
  input wire logic [7:0]  enc_rd_data,
  input wire logic [7:0]  frame_index
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  chk_frame_range: assert property (frame_index <= 8'd191) else $error("frame range");
  chk_frame_step: assert property ($changed(frame_index) |->
    frame_index == $past(frame_index) + 8'd1 || frame_index == 8'h00) else $error("frame step");
  chk_block_pulse: assert property (block_start |=> !block_start) else $error("block pulse");
  chk_pair_pulse: assert property (pair_valid |=> !pair_valid) else $error("pair pulse");
  chk_left_first: assert property (pair_valid |-> $stable(left_word)) else $error("left moved");
  chk_enc_range: assert property (enc_rd_idx > 6'd47 |=> enc_rd_data == 8'h00) else $error("enc range");
  chk_oe_idle: assert property (cp_cs_n [*8] |-> !cp_cdout_oe) else $error("oe idle");
  chk_int_reset: assert property ($rose(rst_n) |-> int_n) else $error("int at reset");
endmodule : atic_ctrl_sva

bind atic_ctrl atic_ctrl_sva i_sva (.ref_clk, .rst_n, .cp_cs_n, .cp_cdout_oe, .int_n, .pair_valid,
  .block_start, .enc_rd_idx, .enc_rd_data, .frame_index, .left_word);

// ### dv/atic_host.sv
// Purpose: host controller model on the control port
// Assumes: cclk half period of 10 ref_clk cycles
// Notes:   cdin shows the inverse of its last bit while deselected
module atic_host (
  input wire logic ref_clk,
  input wire logic cp_cdout,
  output logic     cp_cs_n = 1'b1,
  output logic     cp_cclk = 1'b0,
  output logic     cp_cdin = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  task automatic half();
    repeat (10) @(posedge ref_clk);
  endtask : half
  // one byte msb first, read bit taken at each cclk rise
  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      cp_cdin <= tx[i];
      half();
      cp_cclk <= 1'b1;
      rx[i] = cp_cdout;
      half();
      cp_cclk <= 1'b0;
    end
  endtask : byte_io
  // header, ignored byte, one data byte; reaches a register or the host-side buffer
  task automatic xfer(input logic [7:0] hdr, wd, output logic [7:0] rd);
    cp_cs_n <= 1'b0;
    half();
    byte_io(hdr, rd);
    byte_io(8'h00, rd);
    byte_io(wd, rd);
    cp_cs_n <= 1'b1;
    cp_cdin <= ~cp_cdin;
    half();
  endtask : xfer
endmodule : atic_host

// ### dv/atic_ctrl_bench.sv
// Purpose: self-checking bench for atic_ctrl
// Assumes: atic_host drives the control port
// Notes:   fast frame sync lets a status block fit the run
module atic_ctrl_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk = 0, rst_n = 0, sclk = 0, frame_sync = 0, serial_audio_in = 0, data_slip = 0, fast = 0;
  logic        cp_cs_n, cp_cclk, cp_cdin, cp_cdout, int_n, pair_valid, block_start;
  logic [23:0] left_word, right_word, l, r;
  logic [7:0]  enc_rd_data, frame_index, rd, v, hbuf[48];
  logic [7:0]  msk[4] = '{8'h00, atic_pkg::ENABLE_MASK, atic_pkg::TRIGGER_MASK, atic_pkg::BUFCTL_MASK};
  logic [5:0]  enc_rd_idx = 0;
  int          failures = 0, check_count = 0;
  atic_host i_host (.ref_clk, .cp_cdout, .cp_cs_n, .cp_cclk, .cp_cdin);
  atic_ctrl i_dut (.ref_clk, .rst_n, .cp_cs_n, .cp_cclk, .cp_cdin, .cp_cdout, .cp_cdout_oe(), .int_n, .sclk,
    .frame_sync, .serial_audio_in, .left_word, .right_word, .pair_valid, .data_slip, .enc_rd_idx,
    .enc_rd_data, .frame_index, .block_start);
  initial forever #5 ref_clk = ~ref_clk;
  // frame sync kept running, 60 cycles a frame
  always begin
    repeat (30) @(posedge ref_clk);
    if (fast) frame_sync <= ~frame_sync;
  end
  task automatic chk(input logic [23:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic print_verdict();
    if (failures == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  task automatic wait_for(ref logic s, input logic lvl, input int n);
    while (s !== lvl) begin
      @(posedge ref_clk);
      n--;
      if (n == 0) begin
        failures++;
        print_verdict();
      end
    end
  endtask : wait_for
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    i_host.xfer({2'b00, a}, d, rd);
  endtask : wr
  task automatic rchk(input logic [5:0] a, input logic [7:0] e);
    i_host.xfer({2'b10, a}, 8'h00, rd);
    chk(rd, e);
  endtask : rchk
  // one stereo frame behind a right-phase prefix, then the closing sync edge
  task automatic frame(input logic d, e, p, input logic [23:0] lw, rw);
    frame_sync <= p;
    repeat (25) @(posedge ref_clk);
    for (int ph = 0; ph < 2; ph++) begin
      frame_sync <= ~p ^ ph[0];
      for (int k = 0; k < 24 + d; k++) begin
        serial_audio_in <= (k < d) ? ~serial_audio_in : (ph ? rw[23 + d - k] : lw[23 + d - k]);
        sclk <= e;
        repeat (6) @(posedge ref_clk);
        sclk <= ~e;
        repeat (6 + k[0]) @(posedge ref_clk);
      end
    end
    frame_sync <= ~p;
    wait_for(pair_valid, 1'b1, 40);
    chk(left_word, lw);
    chk(right_word, rw);
  endtask : frame
  initial begin
    void'($urandom(98));
    repeat (4) @(posedge ref_clk);
    rst_n <= 1;
    repeat (2) @(posedge ref_clk);
    for (int a = 0; a < 8; a++) rchk(a[5:0], a == 2 ? 8'h03 : 8'h00);
    for (int a = 4; a < 8; a++) begin
      v = $urandom;
      wr(a[5:0], v);
      rchk(a[5:0], v & msk[a - 4]);
    end
    wr(6'h02, 8'h02);
    for (int c = 0; c < 8; c++) begin
      wr(6'h03, {c[2:0], 5'h00});
      l = $urandom;
      r = $urandom;
      frame(c[0], c[1], c[2], l, r);
    end
    // copy held while the host-side buffer is filled
    fast <= 1;
    wr(6'h07, 8'h01);
    wr(6'h05, 8'h01);
    wr(6'h06, 8'h02);
    i_host.xfer(8'h84, 8'h00, rd);
    for (int i = 0; i < 48; i++) begin
      hbuf[i] = $urandom;
      wr(6'(i + 8), hbuf[i]);
    end
    rchk(6'h37, hbuf[47]);
    chk(int_n, 1'b1);
    wait_for(block_start, 1'b1, 12000);
    wr(6'h07, 8'h00);
    wait_for(int_n, 1'b0, 12000);
    chk(frame_index >= 8'd184, 1'b1);
    rchk(6'h04, 8'h01);
    for (int i = 0; i < 64; i++) begin
      enc_rd_idx <= i[5:0];
      repeat (2) @(posedge ref_clk);
      chk(enc_rd_data, i < 48 ? hbuf[i] : 8'h00);
    end
    wr(6'h05, 8'h06);
    wr(6'h06, 8'h00);
    i_host.xfer(8'h84, 8'h00, rd);
    wait_for(int_n, 1'b0, 12000);
    chk(frame_index, 8'h00);
    rchk(6'h04, 8'h02);
    wr(6'h05, 8'h02);
    wr(6'h06, 8'h04);
    i_host.xfer(8'h84, 8'h00, rd);
    data_slip <= 1;
    repeat (5) @(posedge ref_clk);
    chk(int_n, 1'b1);
    data_slip <= 0;
    wait_for(int_n, 1'b0, 10);
    rchk(6'h04, 8'h02);
    print_verdict();
  end
endmodule : atic_ctrl_bench
